// >>> rtl/eae_exit_events.v
`timescale 1ns/10ps
`default_nettype none
`include "eae_regs.vh"
module eae_exit_events
(
	input  wire        ref_clk,
	input  wire        reset,
	input  wire        enclaveEnter,
	input  wire        enclaveLeave,
	input  wire        smiEvent,
	input  wire        dualMonitorOn,
	input  wire        initEvent,
	input  wire        vmxRoot,
	input  wire        vmxNonRoot,
	input  wire        bootProcessor,
	input  wire        startupIpi,
	input  wire        secureLaunchInstr,
	input  wire        launchEntryEvent,
	input  wire        launchExitActive,
	input  wire        respondingProcessor,
	input  wire        enclaveInstrDone,
	input  wire        enclaveInstrFault,
	input  wire        enclaveInstrError,
	input  wire        safeModeCapable,
	input  wire [7:0]  firmwareThreshold,
	input  wire        moduleLaunchReq,
	input  wire        moduleSigned,
	input  wire [7:0]  moduleVersion,
	input  wire        dmaReq,
	input  wire        dmaReservedHit,
	input  wire        saveMapRead,
	input  wire [15:0] saveMapAddr,
	input  wire        msrRdEn,
	input  wire [11:0] msrRdAddr,
	output reg         enclaveMode,
	output reg         asyncExitPulse,
	output reg         toSmmHandler,
	output reg         toSmmMonitor,
	output reg         saveMapFlag,
	output reg  [31:0] saveMapData,
	output reg         exitReasonFlag,
	output reg         guestIntrFlag,
	output reg         vmExitPulse,
	output reg         powerOnInit,
	output reg         firmwareStart,
	output reg         waitStartup,
	output reg         invalidOpcode,
	output reg         pauseExec,
	output reg         launchShutdown,
	output reg         launchGranted,
	output reg         dmaGrant,
	output reg         dmaRefuse,
	output wire [63:0] msrData,
	output wire        msrValid
);
	// ****************************************
	// States
	// ****************************************
	localparam [3:0] ST_RUN   = 4'b0001;
	localparam [3:0] ST_EXIT  = 4'b0010;
	localparam [3:0] ST_WAIT  = 4'b0100;
	localparam [3:0] ST_PAUSE = 4'b1000;

	localparam [2:0] CAUSE_SMI    = 3'b001;
	localparam [2:0] CAUSE_INIT   = 3'b010;
	localparam [2:0] CAUSE_LAUNCH = 3'b100;

	reg  [3:0] state;
	reg  [3:0] next_state;
	reg  [2:0] cause;
	reg        causeDual;
	reg        causeNonRoot;
	reg        causeBoot;
	reg        exitFromEnclave;
	reg  [1:0] ipiCount;
	reg  [7:0] msrThreshold;
	wire       lockState;
	wire       instrOk;
	wire       smiTake;
	wire       initTake;
	wire       launchTake;
	wire       anyExit;

	assign instrOk    = enclaveInstrDone & ~enclaveInstrFault & ~enclaveInstrError;
	assign smiTake    = enclaveMode & smiEvent;
	assign initTake   = enclaveMode & initEvent & ~vmxRoot;
	assign launchTake = enclaveMode & launchEntryEvent & respondingProcessor;
	assign anyExit    = state == ST_RUN && (smiTake || initTake || launchTake);

	// ****************************************
	// Version status register
	// ****************************************
	eae_status_reg uStatus
	(
		.refClk                 (ref_clk),
		.reset                  (reset),
		.successfulEnclaveInstr (enclaveMode & instrOk),
		.safeModeCapable        (safeModeCapable),
		.firmwareThreshold      (firmwareThreshold),
		.rdEn                   (msrRdEn),
		.rdAddr                 (msrRdAddr),
		.rdData                 (msrData),
		.rdValid                (msrValid),
		.lockState              (lockState)
	);

	function versionBelow;
		input [7:0] ver;
		input [7:0] thr;
		begin
			versionBelow = ver < thr;
		end
	endfunction

	// ****************************************
	// Event sequencer
	// ****************************************
	always @*
	begin
		next_state = state;
		case (state)
			ST_RUN:
			begin
				if (anyExit)
					next_state = ST_EXIT;
				else if (enclaveMode && respondingProcessor && launchExitActive)
					next_state = ST_PAUSE;
			end
			ST_EXIT:
			begin
				if (cause == CAUSE_LAUNCH)
					next_state = ST_WAIT;
				else if (cause == CAUSE_INIT && !causeNonRoot && !causeBoot)
					next_state = ST_WAIT;
				else
					next_state = ST_RUN;
			end
			ST_WAIT:
			begin
				if (ipiCount == 2'd1 && startupIpi)
					next_state = ST_RUN;
			end
			ST_PAUSE:
			begin
				if (!launchExitActive)
					next_state = ST_RUN;
			end
			default:
				next_state = ST_RUN;
		endcase
	end

	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			state           <= ST_RUN;
			cause           <= CAUSE_SMI;
			causeDual       <= 1'b0;
			causeNonRoot    <= 1'b0;
			causeBoot       <= 1'b0;
			enclaveMode     <= 1'b0;
			exitFromEnclave <= 1'b0;
			ipiCount        <= 2'd0;
		end
		else
		begin
			state <= next_state;
			if (anyExit)
			begin
				if (smiTake)
					cause <= CAUSE_SMI;
				else if (initTake)
					cause <= CAUSE_INIT;
				else
					cause <= CAUSE_LAUNCH;
				causeDual       <= dualMonitorOn;
				causeNonRoot    <= vmxNonRoot;
				causeBoot       <= bootProcessor;
				enclaveMode     <= 1'b0;
				exitFromEnclave <= 1'b1;
			end
			else if (state == ST_RUN && smiEvent)
				exitFromEnclave <= 1'b0;
			else if (state == ST_RUN && enclaveLeave)
				enclaveMode <= 1'b0;
			else if (state == ST_RUN && enclaveEnter)
				enclaveMode <= 1'b1;
			// Waiting never in enclave; stray IPIs dropped
			if (state != ST_WAIT)
				ipiCount <= 2'd0;
			else if (startupIpi && ipiCount != 2'd1)
				ipiCount <= ipiCount + 2'd1;
		end
	end

	// ****************************************
	// Exit outputs and routing
	// ****************************************
	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			asyncExitPulse <= 1'b0;
			toSmmHandler   <= 1'b0;
			toSmmMonitor   <= 1'b0;
			saveMapFlag    <= 1'b0;
			exitReasonFlag <= 1'b0;
			guestIntrFlag  <= 1'b0;
			vmExitPulse    <= 1'b0;
			powerOnInit    <= 1'b0;
			firmwareStart  <= 1'b0;
			waitStartup    <= 1'b0;
			pauseExec      <= 1'b0;
		end
		else
		begin
			asyncExitPulse <= anyExit;
			toSmmHandler   <= 1'b0;
			toSmmMonitor   <= 1'b0;
			vmExitPulse    <= 1'b0;
			powerOnInit    <= 1'b0;
			firmwareStart  <= 1'b0;
			if (state == ST_RUN && smiEvent && !anyExit)
				saveMapFlag <= 1'b0;
			if (state == ST_EXIT)
			begin
				case (cause)
					CAUSE_SMI:
					begin
						toSmmHandler   <= ~causeDual;
						saveMapFlag    <= ~causeDual;
						toSmmMonitor   <= causeDual;
						vmExitPulse    <= causeDual;
						exitReasonFlag <= causeDual;
						guestIntrFlag  <= causeDual;
					end
					CAUSE_INIT:
					begin
						vmExitPulse    <= causeNonRoot;
						exitReasonFlag <= causeNonRoot;
						guestIntrFlag  <= 1'b0;
						powerOnInit    <= ~causeNonRoot;
						firmwareStart  <= ~causeNonRoot & causeBoot;
					end
					default:
					begin
						exitReasonFlag <= 1'b0;
						guestIntrFlag  <= 1'b0;
					end
				endcase
			end
			waitStartup <= next_state == ST_WAIT;
			pauseExec   <= next_state == ST_PAUSE;
		end
	end

	// ****************************************
	// Save-map read port, flag not writable
	// ****************************************
	always @(posedge ref_clk)
	begin
		if (reset)
			saveMapData <= 32'h00000000;
		else if (saveMapRead && saveMapAddr == `EAE_SAVE_MAP_OFFSET)
			saveMapData <= {30'h00000000, saveMapFlag & exitFromEnclave, 1'b0};
		else
			saveMapData <= 32'h00000000;
	end

	// ****************************************
	// Invalid opcode, launch checks, DMA filter
	// ****************************************
	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			invalidOpcode  <= 1'b0;
			launchShutdown <= 1'b0;
			launchGranted  <= 1'b0;
			dmaGrant       <= 1'b0;
			dmaRefuse      <= 1'b0;
		end
		else
		begin
			invalidOpcode <= enclaveMode & secureLaunchInstr;
			// Enclave state is untouched by launches
			launchShutdown <= moduleLaunchReq & moduleSigned & lockState
				& versionBelow(moduleVersion, msrThreshold);
			launchGranted  <= moduleLaunchReq & moduleSigned & ~(lockState
				& versionBelow(moduleVersion, msrThreshold));
			dmaGrant  <= dmaReq & ~dmaReservedHit;
			dmaRefuse <= dmaReq & dmaReservedHit;
		end
	end

	always @(posedge ref_clk)
	begin
		if (reset)
			msrThreshold <= `EAE_THRESH_RESET;
		else if (!lockState)
			msrThreshold <= firmwareThreshold;
	end
endmodule // eae_exit_events
`default_nettype wire

// >>> rtl/eae_regs.vh
`ifndef EAE_REGS_VH
`define EAE_REGS_VH
// Model-specific register address
`define EAE_STATUS_ADDR       12'h500
// Status register fields
`define EAE_LOCK_BIT          0
`define EAE_THRESH_LSB        16
`define EAE_THRESH_MSB        23
`define EAE_REG_WIDTH         64
// Save-map field carrying the interruption flag
`define EAE_SAVE_MAP_OFFSET   16'h7ee0
`define EAE_SAVE_MAP_BIT      1
// Reset values
`define EAE_STATUS_RESET      64'h0000000000000000
`define EAE_THRESH_RESET      8'h00
`endif

// >>> rtl/eae_status_reg.v
`timescale 1ns/10ps
`default_nettype none
`include "eae_regs.vh"
module eae_status_reg
(
	input  wire        refClk,
	input  wire        reset,
	input  wire        successfulEnclaveInstr,
	input  wire        safeModeCapable,
	input  wire [7:0]  firmwareThreshold,
	input  wire        rdEn,
	input  wire [11:0] rdAddr,
	output reg  [63:0] rdData,
	output reg         rdValid,
	output reg         lockState
);
	reg  [7:0]  lockedThreshold;
	wire [7:0]  threshField;
	wire [63:0] statusWord;

	// ****************************************
	// Threshold lock
	// ****************************************
	always @(posedge refClk)
	begin
		if (reset)
		begin
			lockState       <= 1'b0;
			lockedThreshold <= `EAE_THRESH_RESET;
		end
		else if (!lockState && successfulEnclaveInstr)
		begin
			lockState       <= 1'b1;
			lockedThreshold <= firmwareThreshold;
		end
	end

	assign threshField = lockState ? lockedThreshold : firmwareThreshold;

	// Reserved bits zero, field zero without capability
	assign statusWord = {40'h0000000000,
		(safeModeCapable ? threshField : 8'h00), 15'h0000, lockState};

	// ****************************************
	// Read-only access; writes have no path
	// ****************************************
	always @(posedge refClk)
	begin
		if (reset)
		begin
			rdData  <= `EAE_STATUS_RESET;
			rdValid <= 1'b0;
		end
		else
		begin
			rdValid <= rdEn;
			if (rdEn && rdAddr == `EAE_STATUS_ADDR)
				rdData <= statusWord;
			else
				rdData <= `EAE_STATUS_RESET;
		end
	end
endmodule // eae_status_reg
`default_nettype wire

// >>> verif/eae_exit_events_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module eae_exit_checker
(
	input wire logic        ref_clk,
	input wire logic        reset,
	input wire logic        enclaveMode,
	input wire logic        smiEvent,
	input wire logic        dualMonitorOn,
	input wire logic        initEvent,
	input wire logic        vmxRoot,
	input wire logic        vmxNonRoot,
	input wire logic        secureLaunchInstr,
	input wire logic        dmaReq,
	input wire logic        dmaReservedHit,
	input wire logic        asyncExitPulse,
	input wire logic        toSmmHandler,
	input wire logic        toSmmMonitor,
	input wire logic        saveMapFlag,
	input wire logic        exitReasonFlag,
	input wire logic        vmExitPulse,
	input wire logic        waitStartup,
	input wire logic        invalidOpcode,
	input wire logic        dmaRefuse,
	input wire logic        dmaGrant,
	input wire logic        pauseExec,
	input wire logic        launchEntryEvent,
	input wire logic        enclaveLeave,
	input wire logic        msrValid,
	input wire logic [63:0] msrData
);
	// ********
	// Exit, opcode, DMA and status checks
	// ********
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	chk_smi_handler: assert property
		(smiEvent && enclaveMode && !dualMonitorOn && !pauseExec
			|=> (asyncExitPulse && !enclaveMode)
			##1 (toSmmHandler && saveMapFlag))
		else $error("smi exit to handler wrong");
	chk_smi_monitor: assert property
		(smiEvent && enclaveMode && dualMonitorOn && !pauseExec
			|=> asyncExitPulse
			##1 (toSmmMonitor && vmExitPulse && exitReasonFlag))
		else $error("smi exit to monitor wrong");
	chk_init_blocked: assert property
		(initEvent && enclaveMode && vmxRoot && !smiEvent
			&& !launchEntryEvent && !enclaveLeave
			|=> enclaveMode && !asyncExitPulse)
		else $error("init under root not blocked");
	chk_init_nonroot: assert property
		(initEvent && enclaveMode && vmxNonRoot && !vmxRoot
			&& !smiEvent && !pauseExec
			|=> asyncExitPulse ##1 (vmExitPulse && exitReasonFlag))
		else $error("init in non-root wrong");
	chk_wait_outside: assert property
		(waitStartup |-> !enclaveMode)
		else $error("waiting while in enclave");
	chk_launch_opcode: assert property
		(secureLaunchInstr && enclaveMode |=> invalidOpcode)
		else $error("no invalid opcode");
	chk_dma_refuse: assert property
		(dmaReq && dmaReservedHit |=> dmaRefuse && !dmaGrant)
		else $error("reserved dma not refused");
	chk_msr_reserved: assert property
		(msrValid |-> msrData[15:1] == 15'h0
			&& msrData[63:24] == 40'h0)
		else $error("reserved status bits set");
endmodule // eae_exit_checker
bind eae_exit_events eae_exit_checker eae_exit_checker_i
(
	.ref_clk           (ref_clk),
	.reset             (reset),
	.enclaveMode       (enclaveMode),
	.smiEvent          (smiEvent),
	.dualMonitorOn     (dualMonitorOn),
	.initEvent         (initEvent),
	.vmxRoot           (vmxRoot),
	.vmxNonRoot        (vmxNonRoot),
	.secureLaunchInstr (secureLaunchInstr),
	.dmaReq            (dmaReq),
	.dmaReservedHit    (dmaReservedHit),
	.asyncExitPulse    (asyncExitPulse),
	.toSmmHandler      (toSmmHandler),
	.toSmmMonitor      (toSmmMonitor),
	.saveMapFlag       (saveMapFlag),
	.exitReasonFlag    (exitReasonFlag),
	.vmExitPulse       (vmExitPulse),
	.waitStartup       (waitStartup),
	.invalidOpcode     (invalidOpcode),
	.dmaRefuse         (dmaRefuse),
	.dmaGrant          (dmaGrant),
	.pauseExec         (pauseExec),
	.launchEntryEvent  (launchEntryEvent),
	.enclaveLeave      (enclaveLeave),
	.msrValid          (msrValid),
	.msrData           (msrData)
);
`default_nettype wire

// >>> verif/eae_fw_model.sv
`timescale 1ns/10ps
`default_nettype none
module eae_fw_model
(
	input wire logic [63:0] statusWord,
	input wire logic [7:0]  version,
	output logic            launchOk
);
	// ********
	// Launch decision of firmware
	// ********
	assign launchOk = !statusWord[0] || version > statusWord[23:16];
endmodule // eae_fw_model
`default_nettype wire

// >>> verif/test_enclave_async_exit_events.sv
`timescale 1ns/10ps
`default_nettype none
module test_enclave_async_exit_events;
	// ********
	// Stimulus and model
	// ********
	logic ref_clk, reset, enclaveEnter, enclaveLeave, smiEvent, dualMonitorOn;
	logic initEvent, vmxRoot, vmxNonRoot, bootProcessor, startupIpi, swOk;
	logic secureLaunchInstr, launchEntryEvent, launchExitActive;
	logic respondingProcessor, enclaveInstrDone, enclaveInstrFault;
	logic enclaveInstrError, safeModeCapable, moduleLaunchReq, moduleSigned;
	logic dmaReq, dmaReservedHit, saveMapRead, msrRdEn, msrValid, waitStartup;
	logic enclaveMode, asyncExitPulse, toSmmHandler, toSmmMonitor, saveMapFlag;
	logic exitReasonFlag, guestIntrFlag, vmExitPulse, powerOnInit, pauseExec;
	logic firmwareStart, invalidOpcode, launchShutdown, launchGranted;
	logic dmaGrant, dmaRefuse;
	logic [7:0]  firmwareThreshold, moduleVersion, thr;
	logic [15:0] saveMapAddr;
	logic [11:0] msrRdAddr;
	logic [31:0] saveMapData;
	logic [63:0] msrData, lastStatus;
	int          errors, n_checks, cyc, mEnc, mLock, mThr, mFlag, seed, k;
	eae_exit_events eae_exit_events_i (.*);
	eae_fw_model eae_fw_model_i (.statusWord(lastStatus),
		.version(moduleVersion), .launchOk(swOk));
	initial
	begin
		ref_clk = 0;
		forever #25 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			errors++;
			final_report;
		end
	end
	task step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task final_report;
		if (errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task ev(input int e);
		{startupIpi, launchEntryEvent, initEvent, smiEvent} = 4'h1 << e;
		step(1);
		{startupIpi, launchEntryEvent, initEvent, smiEvent} = 4'h0;
		step(1);
	endtask
	task enter;
		enclaveEnter = 1;
		step(1);
		enclaveEnter = 0;
		step(2);
		mEnc = 1;
		chk("mode", enclaveMode, mEnc);
	endtask
	task rdMsr;
		{msrRdEn, msrRdAddr} = {1'b1, 12'h500};
		step(1);
		msrRdEn = 0;
		lastStatus = msrData;
		chk("valid", msrValid, 1);
		chk("msr", msrData, mLock | (mThr << 16));
	endtask
	task rdMap;
		{saveMapRead, saveMapAddr} = {1'b1, 16'h7ee0};
		step(1);
		saveMapRead = 0;
		chk("map", saveMapData, mFlag << 1);
	endtask
	task launch(input logic [7:0] v, input logic bad);
		moduleVersion = v;
		step(1);
		moduleLaunchReq = swOk | bad;
		step(1);
		moduleLaunchReq = 0;
		chk("shut", launchShutdown, moduleSigned && mLock && v < mThr);
		chk("grant", launchGranted,
			moduleSigned && !(mLock && v < mThr));
	endtask
	initial
	begin
		{enclaveEnter, enclaveLeave, smiEvent, dualMonitorOn, initEvent,
			vmxRoot, vmxNonRoot, bootProcessor, startupIpi, secureLaunchInstr,
			launchEntryEvent, launchExitActive, respondingProcessor,
			enclaveInstrDone, enclaveInstrFault, enclaveInstrError,
			safeModeCapable, moduleLaunchReq, dmaReq, dmaReservedHit,
			saveMapRead, msrRdEn} = '0;
		{firmwareThreshold, moduleVersion, saveMapAddr, msrRdAddr} = '0;
		{errors, n_checks, cyc, mEnc, mLock, mThr, mFlag} = '0;
		lastStatus = 0;
		moduleSigned = 1;
		seed = 32'hb2a2;
		thr = 8'h10 | ($random(seed) & 8'h3f);
		firmwareThreshold = thr;
		reset = 1;
		step(2);
		reset = 0;
		chk("mode", enclaveMode, 0);
		rdMsr;
		safeModeCapable = 1;
		mThr = thr;
		step(1);
		rdMsr;
		launch(thr - 1, 0);
		enter;
		{enclaveInstrDone, enclaveInstrError} = 2'b11;
		step(1);
		{enclaveInstrFault, enclaveInstrError} = 2'b10;
		step(1);
		{enclaveInstrDone, enclaveInstrFault} = 2'b00;
		rdMsr;
		enclaveInstrDone = 1;
		step(1);
		enclaveInstrDone = 0;
		mLock = 1;
		firmwareThreshold = thr + 8;
		step(1);
		rdMsr;
		launch(thr - 1, 1);
		launch(thr + 1, 0);
		moduleSigned = 0;
		launch(thr + 1, 1);
		moduleSigned = 1;
		secureLaunchInstr = 1;
		step(1);
		secureLaunchInstr = 0;
		chk("ud", invalidOpcode, 1);
		ev(0);
		mEnc = 0;
		mFlag = 1;
		chk("handler", toSmmHandler, 1);
		chk("mode", enclaveMode, mEnc);
		rdMap;
		ev(0);
		mFlag = 0;
		rdMap;
		enter;
		dualMonitorOn = 1;
		ev(0);
		dualMonitorOn = 0;
		chk("monitor", toSmmMonitor, 1);
		chk("flags", {exitReasonFlag, guestIntrFlag}, 2'b11);
		enter;
		vmxRoot = 1;
		ev(1);
		chk("mode", enclaveMode, 1);
		{vmxRoot, vmxNonRoot} = 2'b01;
		ev(1);
		vmxNonRoot = 0;
		chk("vmexit", vmExitPulse, 1);
		chk("poweron", powerOnInit, 0);
		chk("mode", enclaveMode, 0);
		enter;
		ev(3);
		chk("ipi", {enclaveMode, waitStartup}, 2'b10);
		for (k = 0; k < 3; k++)
		begin
			enter;
			bootProcessor = (k == 0);
			respondingProcessor = (k == 2);
			ev(k == 2 ? 2 : 1);
			mEnc = 0;
			chk("wait", waitStartup, k != 0);
			chk("fwstart", firmwareStart, k == 0);
			chk("poweron", powerOnInit, k != 2);
			chk("mode", enclaveMode, mEnc);
			ev(3);
			ev(3);
			chk("wait", waitStartup, 0);
			rdMsr;
		end
		enter;
		{respondingProcessor, launchExitActive} = 2'b11;
		step(2);
		chk("pause", pauseExec, 1);
		launchExitActive = 0;
		step(2);
		chk("resume", {pauseExec, enclaveMode}, 2'b01);
		enclaveLeave = 1;
		step(1);
		enclaveLeave = 0;
		secureLaunchInstr = 1;
		step(1);
		secureLaunchInstr = 0;
		chk("mode", enclaveMode, 0);
		chk("ud", invalidOpcode, 0);
		for (k = 0; k < 2; k++)
		begin
			{dmaReq, dmaReservedHit} = {1'b1, k[0]};
			step(1);
			dmaReq = 0;
			chk("dma", {dmaRefuse, dmaGrant}, k ? 2'b10 : 2'b01);
		end
		final_report;
	end
endmodule // test_enclave_async_exit_events
`default_nettype wire
